// ==== dv/host_read_model.sv ====
// host memory controller: drives the link clock and strobes, captures read words into got
// assumes the bench runs one frame at a time and sets run to keep the clock going between frames
`include "burst_read_config_map.svh"

module host_read_model (
  output logic                         link_clk,
  output logic                         address_valid_n,
  output logic                         chip_enable_n,
  output logic                         output_enable_n,
  output logic                         write_enable_n,
  output logic [`LINK_ADDR_W-1:0]      link_addr,
  input  wire logic [`LINK_DATA_W-1:0] data_out,
  input  wire logic                    wait_out,
  input  wire logic                    wait_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        run = 1'b0;
  logic [15:0] got[$];

  initial begin
    link_clk = 1'b0;
    address_valid_n = 1'b1;
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    write_enable_n = 1'b1;
    link_addr = '0;
    #7;
    // parks low outside frames unless run holds it going
    forever #32 if (run || link_clk) link_clk = ~link_clk;
  end

  task automatic burst(input logic [22:0] a, input int n, input logic wr, input logic sync,
                       input logic wp, input logic early);
    logic seen;
    seen = 1'b0;
    run = 1'b1;
    @(posedge link_clk);
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    write_enable_n <= !wr;
    address_valid_n <= !sync;
    link_addr <= a;
    @(posedge link_clk);
    address_valid_n <= 1'b1;
    if (wr) repeat (10) @(posedge link_clk);
    else if (sync) begin
      // follow wait: asserted, then released; bounded so a stuck wait cannot hang the frame
      for (int k = 0; k < 40; k++) begin
        @(posedge link_clk);
        if (wait_oe === 1'b1 && wait_out === wp) seen = 1'b1;
        else if (seen) break;
      end
      if (early) @(posedge link_clk);
      repeat (n) begin
        got.push_back(data_out);
        @(posedge link_clk);
      end
    end else begin
      for (int k = 0; k < n; k++) begin
        link_addr <= a + 23'(k);
        repeat (6) @(posedge link_clk);
        got.push_back(data_out);
      end
    end
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    write_enable_n <= 1'b1;
    link_addr <= ~link_addr;
    // keep clocking until the block has seen the deselect and let go of its pins
    repeat (4) @(posedge link_clk);
    run = 1'b0;
  endtask
endmodule

// ==== dv/read_cfg_properties.sv ====
// checker for the read configuration decoder, bound to its top module
// assumes writes during a link access touch no mode, latency or wait field, so the shadow copy matches the link side
`include "burst_read_config_map.svh"

module read_cfg_properties (
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire logic [`REG_ADDR_W-1:0]  reg_addr,
  input wire logic [`REG_DATA_W-1:0]  reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [`REG_DATA_W-1:0]  reg_rdata,
  input wire logic                    link_clk,
  input wire logic                    address_valid_n,
  input wire logic                    chip_enable_n,
  input wire logic                    output_enable_n,
  input wire logic                    write_enable_n,
  input wire logic [`LINK_ADDR_W-1:0] link_addr,
  input wire logic [`LINK_DATA_W-1:0] data_out,
  input wire logic                    data_oe,
  input wire logic                    wait_out,
  input wire logic                    wait_oe,
  input wire logic [`LINK_ADDR_W-1:0] array_addr,
  input wire logic [`LINK_DATA_W-1:0] array_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] cfg_q;
  logic [4:0]  cnt_q;
  logic        wp;

  assign wp = cfg_q[`WP_BIT];

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) cfg_q <= `RDCFG_RESET;
    else if (reg_wr && reg_addr == `RDCFG_INDEX) cfg_q <= reg_wdata & `RDCFG_WR_MASK;
  end

  // counts link samples with wait asserted; cleared as soon as it drops
  always_ff @(posedge link_clk) begin
    if (srst || !wait_oe || wait_out != wp) cnt_q <= 5'h0;
    else cnt_q <= cnt_q + 5'h1;
  end

  sequence wait_held;
    $past(wait_oe) && $past(wait_out) == wp;
  endsequence
  sequence wait_dropped;
    wait_oe && wait_out != wp && !cfg_q[`MODE_BIT];
  endsequence

  ////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (srst)
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data not zero outside a read answer");
  a_cfg_readback: assert property (@(posedge core_clk) disable iff (srst)
    $past(reg_rd) && $past(reg_addr) == `RDCFG_INDEX |-> reg_rdata == cfg_q) else $error("config readback wrong");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (srst)
    $past(reg_rd) && $past(reg_addr) > `STATUS_INDEX |-> reg_rdata == '0) else $error("unmapped read not zero");
  a_status_mode: assert property (@(posedge core_clk) disable iff (srst)
    $past(reg_rd) && $past(reg_addr) == `STATUS_INDEX |-> reg_rdata[`ST_ASYNC_BIT] == cfg_q[`MODE_BIT])
    else $error("status mode bit wrong");
  a_wait_latency: assert property (@(posedge link_clk) disable iff (srst)
    wait_held ##0 wait_dropped |-> cnt_q == 5'(cfg_q[`LAT_HI:`LAT_LO]) - 5'(cfg_q[`EARLY_BIT]))
    else $error("wait length does not match latency");
  a_async_wait_idle: assert property (@(posedge link_clk) disable iff (srst)
    cfg_q[`MODE_BIT] && wait_oe |-> wait_out == !wp) else $error("wait asserted in page mode");
  a_write_wait_idle: assert property (@(posedge link_clk) disable iff (srst)
    (!chip_enable_n && !write_enable_n)[*5] |-> !data_oe && (!wait_oe || wait_out != wp))
    else $error("wait or data active during write");
  a_idle_release: assert property (@(posedge link_clk) disable iff (srst)
    chip_enable_n[*5] |-> !wait_oe && !data_oe) else $error("pins driven while deselected");
endmodule

bind burst_read_config_decode read_cfg_properties read_cfg_properties_i (.*);

// ==== dv/test_burst_read_config_decode.sv ====
// self-checking bench for the read configuration decoder with a host model on the link
// assumes the array answers combinationally; the bench plays the array and the register master
`include "burst_read_config_map.svh"

module test_burst_read_config_decode;
  timeunit 1ns;
  timeprecision 100ps;

  logic                      core_clk = 1'b0;
  logic                      srst = 1'b1;
  logic [`REG_ADDR_W-1:0]    reg_addr = '0;
  logic [`REG_DATA_W-1:0]    reg_wdata = '0;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic                      rd_p = 1'b0;
  logic [`REG_DATA_W-1:0]    reg_rdata;
  wire logic                 link_clk;
  wire logic                 address_valid_n;
  wire logic                 chip_enable_n;
  wire logic                 output_enable_n;
  wire logic                 write_enable_n;
  wire logic [`LINK_ADDR_W-1:0] link_addr;
  logic [`LINK_DATA_W-1:0]   data_out;
  logic                      data_oe;
  logic                      wait_out;
  logic                      wait_oe;
  logic [`LINK_ADDR_W-1:0]   array_addr;
  logic [`LINK_DATA_W-1:0]   array_data;
  logic [31:0]               seed = 32'h5;
  logic [15:0]               rq[$];
  logic [15:0]               lq[$];
  logic [15:0]               cfg[4] = '{16'h144F, 16'h1901, 16'h5542, 16'h2009};
  int                        bad_count = 0;
  int                        n_tests = 0;

  burst_read_config_decode burst_read_config_decode_i (.*);
  host_read_model host_read_model_i (.*);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] word(input logic [22:0] a);
    return a[15:0] ^ {a[22:16], 9'h0A5};
  endfunction

  function automatic logic [22:0] nxt(input logic [22:0] s, input int i, input logic [15:0] c);
    logic [22:0] m;
    m = c[2:0] == 3'h1 ? 23'h3 : c[2:0] == 3'h2 ? 23'h7 : 23'h0;
    return (c[3] || m == 0) ? s + 23'(i) : (s & ~m) | ((s + 23'(i)) & m);
  endfunction

  assign array_data = word(array_addr);
  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic note);
    @(posedge core_clk);
    if (note) rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // waits until the config has reached the link side; the link clock must run for that
  task automatic settle();
    host_read_model_i.run = 1'b1;
    for (int k = 0; k < 200; k++) begin
      rd(`STATUS_INDEX, 16'h0, 1'b0);
      @(posedge core_clk);
      if (reg_rdata[`ST_PENDING_BIT] === 1'b0) break;
      if (k == 199) bad_count++;
    end
    host_read_model_i.run = 1'b0;
  endtask

  task automatic final_report();
    if (lq.size() > 0 || rq.size() > 0) bad_count++;
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (rd_p && rq.size() > 0) chk(reg_rdata, rq.pop_front());
    rd_p <= reg_rd;
  end

  always @(posedge link_clk) begin
    while (host_read_model_i.got.size() > 0 && lq.size() > 0) chk(host_read_model_i.got.pop_front(), lq.pop_front());
  end

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    logic [15:0] d;
    logic [22:0] s;
    host_read_model_i.run = 1'b1;
    repeat (16) @(posedge link_clk);
    @(posedge core_clk);
    srst <= 1'b0;
    rd(`RDCFG_INDEX, 16'h994F, 1'b1);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, 16'h0000, 1'b1);
    rd(`RDCFG_INDEX, 16'h994F, 1'b1);
    settle();
    s = 23'(rnd());
    for (int k = 0; k < 4; k++) lq.push_back(word(s + 23'(k)));
    host_read_model_i.burst(s, 4, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) begin
      d = 16'(rnd()) | 16'h1007;
      wr(`RDCFG_INDEX, d);
      rd(`RDCFG_INDEX, d & 16'hFD4F, 1'b1);
    end
    // rising and falling sampling, both wait polarities and delays, wrap and no-wrap
    foreach (cfg[i]) begin
      wr(`RDCFG_INDEX, cfg[i]);
      rd(`RDCFG_INDEX, cfg[i], 1'b1);
      settle();
      s = 23'(rnd());
      for (int k = 0; k < 6; k++) lq.push_back(word(nxt(s, k, cfg[i])));
      fork
        host_read_model_i.burst(s, 6, 1'b0, 1'b1, cfg[i][`WP_BIT], cfg[i][`EARLY_BIT]);
        if (i == 3) begin
          // wrap on a 4-word length lands after the access is taken and must not reach it
          repeat (40) @(posedge core_clk);
          wr(`RDCFG_INDEX, 16'h2001);
        end
      join
    end
    host_read_model_i.burst(s, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    wr(`RDCFG_INDEX, 16'h994F);
    settle();
    for (int k = 0; k < 2; k++) lq.push_back(word(s + 23'(k)));
    host_read_model_i.burst(s, 2, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule

// ==== logic/burst_read_config_decode.sv ====
// read configuration register and the synchronous burst / asynchronous page read path it steers
// assumes the host memory controller drives link_clk and the strobes; array_data answers
// array_addr combinationally within one link clock
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "burst_read_config_map.svh"

module burst_read_config_decode (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire logic [`REG_ADDR_W-1:0]       reg_addr,
  input  wire logic [`REG_DATA_W-1:0]       reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [`REG_DATA_W-1:0]       reg_rdata,
  input  wire logic                         link_clk,
  input  wire logic                         address_valid_n,
  input  wire logic                         chip_enable_n,
  input  wire logic                         output_enable_n,
  input  wire logic                         write_enable_n,
  input  wire logic [`LINK_ADDR_W-1:0]      link_addr,
  output logic      [`LINK_DATA_W-1:0]      data_out,
  output logic                              data_oe,
  output logic                              wait_out,
  output logic                              wait_oe,
  output logic      [`LINK_ADDR_W-1:0]      array_addr,
  input  wire logic [`LINK_DATA_W-1:0]      array_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [2:0] wrap_mask(input logic [2:0] length_code);
    case (length_code)
      `LEN_4WORD: wrap_mask = `WRAP_MASK_4;
      `LEN_8WORD: wrap_mask = `WRAP_MASK_8;
      `LEN_CONT:  wrap_mask = `WRAP_MASK_NONE;
      default:   wrap_mask = `WRAP_MASK_NONE;
    endcase
  endfunction

  // linear successor; with wrap enabled only the low bits inside the burst length advance
  function automatic logic [`LINK_ADDR_W-1:0] next_addr(input logic [`LINK_ADDR_W-1:0] cur,
                                                        input burst_read_pkg::cfg_word_t cfg);
    logic [`LINK_ADDR_W-1:0] lin;
    logic [`LINK_ADDR_W-1:0] msk;
    lin = cur + `LINK_ADDR_W'(1);
    msk = `LINK_ADDR_W'(wrap_mask(cfg[`LEN_HI:`LEN_LO]));
    // a continuous burst has no length to wrap in, so it always runs on
    if (!cfg[`NOWRAP_BIT] && (msk != '0)) begin
      next_addr = (cur & ~msk) | (lin & msk);
    end else begin
      next_addr = lin;
    end
  endfunction

  function automatic logic wait_level(input logic asserted, input logic polarity);
    wait_level = asserted ? polarity : ~polarity;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register side, core_clk

  burst_read_pkg::cfg_word_t rdcfg_q;
  logic                      cfg_busy;
  logic                      cfg_load_q;
  logic                      act_meta_q;
  logic                      act_sync_q;
  logic                      rdcfg_hit;
  logic                      status_hit;

  assign rdcfg_hit  = (reg_addr == `RDCFG_INDEX);
  assign status_hit = (reg_addr == `STATUS_INDEX);

  // reserved and burst order bits are not writable, so the fixed ordering cannot be changed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdcfg_q <= `RDCFG_RESET;
    end else if (reg_wr && rdcfg_hit) begin
      rdcfg_q <= (reg_wdata & `RDCFG_WR_MASK) | `RDCFG_FIXED;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_load_q <= 1'b0;
    end else begin
      cfg_load_q <= reg_wr && rdcfg_hit;
    end
  end

  logic link_active;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_meta_q <= 1'b0;
      act_sync_q <= 1'b0;
    end else begin
      act_meta_q <= link_active;
      act_sync_q <= act_meta_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd && rdcfg_hit) begin
      reg_rdata <= rdcfg_q;
    end else if (reg_rd && status_hit) begin
      reg_rdata                  <= '0;
      reg_rdata[`ST_ACTIVE_BIT]  <= act_sync_q;
      reg_rdata[`ST_PENDING_BIT] <= cfg_busy;
      reg_rdata[`ST_ASYNC_BIT]   <= rdcfg_q[`MODE_BIT];
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset into the link domain

  logic link_rst_meta_q;
  logic link_rst_q;

  always_ff @(posedge link_clk) begin
    link_rst_meta_q <= srst;
    link_rst_q      <= link_rst_meta_q;
  end

  burst_read_pkg::cfg_word_t cfg_live;

  cfg_handshake u_cfg_handshake (
    .src_clk  (core_clk),
    .src_rst  (srst),
    .src_data (rdcfg_q),
    .src_load (cfg_load_q),
    .src_busy (cfg_busy),
    .dst_clk  (link_clk),
    .dst_rst  (link_rst_q),
    .dst_data (cfg_live)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling on both edges, selected by the edge select bit

  logic [`LINK_PIN_W-1:0]  pin_raw;
  logic [`LINK_PIN_W-1:0]  pos_meta_q;
  logic [`LINK_PIN_W-1:0]  pos_sync_q;
  logic [`LINK_PIN_W-1:0]  neg_meta_q;
  logic [`LINK_PIN_W-1:0]  neg_sync_q;
  logic [`LINK_ADDR_W-1:0] addr_meta_q;
  logic [`LINK_ADDR_W-1:0] addr_sync_q;
  logic [`LINK_PIN_W-1:0]  pins;
  logic [`LINK_PIN_W-1:0]  pins_prev_q;

  assign pin_raw = {address_valid_n, chip_enable_n, output_enable_n, write_enable_n};

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      pos_meta_q <= `PIN_IDLE;
      pos_sync_q <= `PIN_IDLE;
    end else begin
      pos_meta_q <= pin_raw;
      pos_sync_q <= pos_meta_q;
    end
  end

  always_ff @(negedge link_clk) begin
    if (link_rst_q) begin
      neg_meta_q <= `PIN_IDLE;
      neg_sync_q <= `PIN_IDLE;
    end else begin
      neg_meta_q <= pin_raw;
      neg_sync_q <= neg_meta_q;
    end
  end

  // the address is held stable by the host around the strobe, so a plain two-stage sample suffices
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      addr_meta_q <= '0;
      addr_sync_q <= '0;
    end else begin
      addr_meta_q <= link_addr;
      addr_sync_q <= addr_meta_q;
    end
  end

  assign pins = cfg_live[`CE_BIT] ? pos_sync_q : neg_sync_q;

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      pins_prev_q <= `PIN_IDLE;
    end else begin
      pins_prev_q <= pins;
    end
  end

  logic chip_on;
  logic out_on;
  logic writing;
  logic adv_taken;

  assign chip_on   = ~pins[`PIN_CE];
  assign out_on    = chip_on & ~pins[`PIN_OE];
  assign writing   = chip_on & ~pins[`PIN_WE];
  // the strobe is taken at its rising edge while the chip is selected
  assign adv_taken = chip_on & pins[`PIN_ADV] & ~pins_prev_q[`PIN_ADV];

  ////////////////////////////////////////////////////////////////////////////////
  // burst engine, link_clk

  burst_read_pkg::burst_state_t state_q;
  burst_read_pkg::cfg_word_t    cfg_burst_q;
  logic [`LAT_HI-`LAT_LO:0]     lat_cnt_q;
  logic [`LAT_HI-`LAT_LO:0]     lat_code;
  logic                         sync_mode;

  assign lat_code  = cfg_burst_q[`LAT_HI:`LAT_LO];
  assign sync_mode = ~cfg_live[`MODE_BIT];

  // the configuration is frozen at the start of each access, but sync_mode reads the mode bit live from cfg_live, so a late mode update still reaches it
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      cfg_burst_q <= `RDCFG_RESET;
    end else if (adv_taken) begin
      cfg_burst_q <= cfg_live;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      state_q <= burst_read_pkg::ST_IDLE;
    end else if (!chip_on || writing) begin
      state_q <= burst_read_pkg::ST_IDLE;
    end else if (adv_taken && sync_mode) begin
      state_q <= burst_read_pkg::ST_LATENCY;
    end else if (adv_taken) begin
      state_q <= burst_read_pkg::ST_IDLE;
    end else begin
      case (state_q)
        burst_read_pkg::ST_IDLE:    state_q <= burst_read_pkg::ST_IDLE;
        burst_read_pkg::ST_LATENCY: begin
          if (lat_cnt_q == lat_code) begin
            state_q <= burst_read_pkg::ST_BURST;
          end
        end
        burst_read_pkg::ST_BURST:   state_q <= burst_read_pkg::ST_BURST;
        default:                    state_q <= burst_read_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      lat_cnt_q <= `LAT_FIRST;
    end else if (adv_taken) begin
      lat_cnt_q <= `LAT_FIRST;
    end else if (state_q == burst_read_pkg::ST_LATENCY) begin
      lat_cnt_q <= lat_cnt_q + `LAT_STEP;
    end
  end

  assign link_active = (state_q != burst_read_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // array address and data

  logic data_edge;
  logic early_edge;

  assign data_edge  = (state_q == burst_read_pkg::ST_LATENCY) && (lat_cnt_q == lat_code) && !adv_taken;
  assign early_edge = (state_q == burst_read_pkg::ST_LATENCY) && (lat_cnt_q + `LAT_STEP == lat_code) &&
                      !adv_taken;

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      array_addr <= '0;
    end else if (adv_taken) begin
      array_addr <= addr_sync_q;
    end else if (data_edge || (state_q == burst_read_pkg::ST_BURST && out_on)) begin
      array_addr <= next_addr(array_addr, cfg_burst_q);
    end else if (!sync_mode && out_on && state_q == burst_read_pkg::ST_IDLE) begin
      array_addr <= addr_sync_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      data_out <= '0;
    end else if (data_edge || (state_q == burst_read_pkg::ST_BURST && out_on)) begin
      data_out <= array_data;
    end else if (!sync_mode && out_on) begin
      data_out <= array_data;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= out_on && !writing;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wait output

  logic wait_asserted;

  localparam burst_read_pkg::cfg_word_t cfg_init = `RDCFG_RESET;

  always_comb begin
    wait_asserted = 1'b0;
    case (state_q)
      burst_read_pkg::ST_LATENCY: begin
        if (adv_taken) begin
          wait_asserted = sync_mode;
        end else if (cfg_burst_q[`EARLY_BIT]) begin
          wait_asserted = !(early_edge || data_edge);
        end else begin
          wait_asserted = !data_edge;
        end
      end
      burst_read_pkg::ST_IDLE:  wait_asserted = adv_taken && sync_mode;
      burst_read_pkg::ST_BURST: wait_asserted = adv_taken && sync_mode;
      default:                  wait_asserted = 1'b0;
    endcase
    if (writing || !chip_on) begin
      wait_asserted = 1'b0;
    end
  end

  // polarity follows the live value while idle and the frozen value during an access
  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      wait_out <= wait_level(1'b0, cfg_init[`WP_BIT]);
    end else if (state_q == burst_read_pkg::ST_IDLE && !adv_taken) begin
      wait_out <= wait_level(1'b0, cfg_live[`WP_BIT]);
    end else if (adv_taken) begin
      wait_out <= wait_level(wait_asserted, cfg_live[`WP_BIT]);
    end else begin
      wait_out <= wait_level(wait_asserted, cfg_burst_q[`WP_BIT]);
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst_q) begin
      wait_oe <= 1'b0;
    end else begin
      wait_oe <= out_on;
    end
  end

endmodule

// ==== logic/burst_read_config_map.svh ====
// constants for the read configuration decoder: register map, field positions, codes
// assumes one 16-bit register word per index on a plain strobe port
`ifndef BURST_READ_CONFIG_MAP_SVH
`define BURST_READ_CONFIG_MAP_SVH

`define REG_ADDR_W       4
`define REG_DATA_W       16
`define RDCFG_INDEX      4'h0
`define STATUS_INDEX     4'h1
`define RDCFG_RESET      16'h994F
`define RDCFG_WR_MASK    16'hFD4F
`define RDCFG_FIXED      16'h0000

`define MODE_BIT         15
`define LAT_HI           14
`define LAT_LO           11
`define WP_BIT           10
`define EARLY_BIT        8
`define ORDER_BIT        7
`define CE_BIT           6
`define NOWRAP_BIT       3
`define LEN_HI           2
`define LEN_LO           0

`define LEN_4WORD        3'h1
`define LEN_8WORD        3'h2
`define LEN_CONT         3'h7
`define WRAP_MASK_4      3'h3
`define WRAP_MASK_8      3'h7
`define WRAP_MASK_NONE   3'h0

`define LAT_FIRST        4'h1
`define LAT_STEP         4'h1

`define ST_ACTIVE_BIT    0
`define ST_PENDING_BIT   1
`define ST_ASYNC_BIT     2

`define LINK_ADDR_W      23
`define LINK_DATA_W      16
`define LINK_PIN_W       4
`define PIN_ADV          3
`define PIN_CE           2
`define PIN_OE           1
`define PIN_WE           0
`define PIN_IDLE         4'hF

`endif

// ==== logic/burst_read_pkg.sv ====
// types shared by the read configuration decoder
// assumes the constant header is included by each design file
package burst_read_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LATENCY,
    ST_BURST
  } burst_state_t;

  typedef logic [15:0] cfg_word_t;
endpackage

// ==== logic/cfg_handshake.sv ====
// word crossing from the register clock into the link clock by a toggle handshake
// assumes both resets are synchronous to their own clocks; the link clock may stop between frames
`include "burst_read_config_map.svh"

module cfg_handshake (
  input  wire logic                    src_clk,
  input  wire logic                    src_rst,
  input  wire burst_read_pkg::cfg_word_t src_data,
  input  wire logic                    src_load,
  output logic                         src_busy,
  input  wire logic                    dst_clk,
  input  wire logic                    dst_rst,
  output burst_read_pkg::cfg_word_t    dst_data
);
  burst_read_pkg::cfg_word_t hold_q;
  logic                      dirty_q;
  logic                      req_q;
  logic                      ack_meta_q;
  logic                      ack_sync_q;
  logic                      req_meta_q;
  logic                      req_sync_q;
  logic                      seen_q;
  logic                      idle;

  assign idle     = (req_q == ack_sync_q);
  assign src_busy = dirty_q | ~idle;

  // a write during a transfer is remembered and resent, so the last value always lands
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      hold_q  <= `RDCFG_RESET;
      dirty_q <= 1'b0;
      req_q   <= 1'b0;
    end else begin
      if (src_load) begin
        dirty_q <= 1'b1;
      end else if (dirty_q && idle) begin
        dirty_q <= 1'b0;
      end
      if (dirty_q && idle && !src_load) begin
        hold_q <= src_data;
        req_q  <= ~req_q;
      end
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= seen_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      seen_q     <= 1'b0;
      dst_data   <= `RDCFG_RESET;
    end else begin
      req_meta_q <= req_q;
      req_sync_q <= req_meta_q;
      if (req_sync_q != seen_q) begin
        dst_data <= hold_q;
        seen_q   <= req_sync_q;
      end
    end
  end
endmodule
